// ===== design/aafc_pkg.sv
// Purpose: shared constants and types of the acquisition FIFO controller
// Assumes: 100 MHz hclk, AHB-Lite register access, 32-bit data
// Notes:   every address, field position and count used by the logic lives here
package aafc_pkg;

    // register byte addresses
    localparam logic [7:0] REG_STATUS1 = 8'h00;
    localparam logic [7:0] REG_STATUS2 = 8'h04;
    localparam logic [7:0] REG_FIFO    = 8'h08;
    localparam logic [7:0] REG_CLEAR   = 8'h0C;
    localparam logic [7:0] REG_CHAN    = 8'h10;
    localparam logic [7:0] REG_RANGE   = 8'h14;
    localparam logic [7:0] REG_CTRL    = 8'h18;
    localparam logic [7:0] REG_CAL_LO  = 8'h1C;
    localparam logic [7:0] REG_CAL_HI  = 8'h20;

    // field positions
    localparam int ST1_AVAIL_BIT = 0;
    localparam int ST1_ERR_BIT   = 1;
    localparam int ST2_OVF_BIT   = 0;
    localparam int ST2_OVR_BIT   = 1;
    localparam int CTRL_DIS_BIT  = 0;
    localparam int RANGE_DIFF_BIT = 2;

    // fifo geometry
    localparam int PTR_W = 9;
    localparam int CNT_W = 10;
    localparam logic [CNT_W-1:0] FIFO_DEPTH = 10'h200;
    localparam int CODE_W = 12;
    localparam int WORD_W = 16;

    // conversion timing: result must be visible within the limit
    localparam int CLK_NS        = 10;
    localparam int CONV_LIMIT_NS = 9500;
    localparam int CONV_LIMIT_CYC = CONV_LIMIT_NS / CLK_NS;
    localparam int CONV_MARGIN_CYC = 4;
    localparam logic [9:0] CONV_CYC = 10'(CONV_LIMIT_CYC - CONV_MARGIN_CYC);

    // reset values
    localparam logic [2:0] CHAN_RST  = 3'h0;
    localparam logic [1:0] RANGE_RST = 2'h0;
    localparam logic       DIFF_RST  = 1'b0;

    // calibration record bytes
    localparam logic [7:0] REC_TYPE     = 8'h81;
    localparam logic [7:0] REC_LEN      = 8'h03;
    localparam logic [7:0] REC_DEFAULT  = 8'hFF;

    // converter setting carried as one word
    typedef struct packed {
        logic       diff;
        logic [1:0] range;
        logic [2:0] chan;
    } aafc_cfg_s;

    // conversion sequencer, gray coded along idle-convert-store
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_CONV  = 2'b01,
        ST_STORE = 2'b11
    } aafc_state_e;

endpackage

// ===== design/aafc_top.sv
// Purpose: converter trigger, 512-word result FIFO and error flags on AHB-Lite
// Assumes: inputs synchronous to hclk; converter code valid when sampled
// Notes:   register reads and writes complete with zero wait states
//
// Overview of operation
// [RULE1] each rising edge of timer output or convert strobe starts one conversion; the code starts none while busy or while the disable bit is set
// [RULE2] host keeps timer output high when pacing by the convert strobe
// [RULE3] result is pushed into the FIFO at the end of each conversion
// [RULE4] FIFO register read returns the oldest result and removes it
// [RULE5] available flag is set while the FIFO holds at least one word
// [RULE6] available flag rises within 9.5 us of the starting edge
// [RULE7] host checks the available flag before each FIFO read
// [RULE8] data error flag shows overflow or overrun having happened
// [RULE9] a push into a full 512-word FIFO sets overflow and drops the word
// [RULE10] a start during a running conversion sets overrun
// [RULE11] any write to the clear register clears the three error flags
// [RULE12] after a clear the FIFO holds exactly one invalid word
// [RULE13] host clears with a zero write and one discarded FIFO read
// [RULE14] result word is a 12-bit signed code sign-extended to 16 bits
// [RULE15] full negative scale reads F800, zero 0000, half positive 0400
// [RULE16] host writes the channel register only when the channel changes
// [RULE17] host sets range and mode before acquisition when defaults misfit
// [RULE18] after reset: single-ended, channel 0, FIFO empty
// [RULE19] calibration record: type 81, length, range code, offset, gain bytes
// [RULE20] only one calibration record exists per range and mode
// [RULE21] available flag sits in bit 0 of the first status register
// [RULE22] range code: single-ended 00/02/03, differential 04/06/07, default FF
// [RULE23] reading an empty FIFO changes neither pointers nor flags
`timescale 1ns/10ps
module aafc_top #(
    parameter logic [7:0] CAL_OFFSET = 8'h00,
    parameter logic [7:0] CAL_GAIN   = 8'h00
) (
    // clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // conversion triggers
    input  wire logic        sample_timer_output,
    input  wire logic        external_convert_strobe,
    // converter
    input  wire logic [11:0] adc_code,
    output logic             adc_start,
    output logic      [5:0]  adc_setting
);

    localparam int PW = aafc_pkg::PTR_W;
    localparam int CW = aafc_pkg::CNT_W;

    // result store, no reset needed on the array
    logic [aafc_pkg::WORD_W-1:0] mem [0:(1 << aafc_pkg::PTR_W)-1];

    logic [PW-1:0]          rd_ptr_r;
    logic [PW-1:0]          wr_ptr_r;
    logic [CW-1:0]          count_r;
    logic                   overflow_r;
    logic                   overrun_r;
    logic                   disable_r;
    aafc_pkg::aafc_cfg_s    cfg_r;
    aafc_pkg::aafc_state_e  state_r;
    aafc_pkg::aafc_state_e  state_nxt;
    logic [9:0]             conv_cnt_r;
    logic                   timer_prev_r;
    logic                   strobe_prev_r;
    logic [11:0]            code_r;
    logic                   wr_pend_r;
    logic [7:0]             wr_addr_r;
    logic [31:0]            hrdata_r;
    logic                   hreadyout_r;
    logic                   adc_start_r;

    // address phase decode
    wire        addr_ok   = hsel & htrans[1] & hready;
    wire        rd_access = addr_ok & ~hwrite;
    wire        wr_access = addr_ok & hwrite;
    wire [7:0]  word_addr = {haddr[7:2], 2'b00};
    wire        rd_fifo   = rd_access & (word_addr == aafc_pkg::REG_FIFO);
    wire        fifo_empty = (count_r == '0);
    wire        fifo_full  = (count_r == aafc_pkg::FIFO_DEPTH);

    // data phase writes land here
    wire        wr_clear  = wr_pend_r & (wr_addr_r == aafc_pkg::REG_CLEAR);
    wire        wr_chan   = wr_pend_r & (wr_addr_r == aafc_pkg::REG_CHAN);
    wire        wr_range  = wr_pend_r & (wr_addr_r == aafc_pkg::REG_RANGE);
    wire        wr_ctrl   = wr_pend_r & (wr_addr_r == aafc_pkg::REG_CTRL);

    // an empty read leaves the fifo alone
    wire        pop       = rd_fifo & ~fifo_empty;        // [RULE23]
    wire        store     = (state_r == aafc_pkg::ST_STORE);
    wire        push      = store & ~fifo_full;           // [RULE9]
    wire        drop      = store & fifo_full;            // [RULE9]

    // start edges; timer high keeps strobe edges visible only through the OR
    wire        timer_rise  = sample_timer_output & ~timer_prev_r;      // [RULE1]
    wire        strobe_rise = external_convert_strobe & ~strobe_prev_r; // [RULE1]
    wire        trigger     = (timer_rise | strobe_rise) & ~disable_r;  // [RULE1]
    wire        busy        = (state_r != aafc_pkg::ST_IDLE);
    wire        overrun_set = trigger & busy;                           // [RULE10]

    // signed code widened to the stored word
    wire [15:0] result_word = {{4{code_r[11]}}, code_r}; // [RULE14] [RULE15]

    // status and record words
    wire        data_error = overflow_r | overrun_r;     // [RULE8]
    wire [7:0]  range_code = {5'h00, cfg_r.diff, cfg_r.range}; // [RULE22]
    wire [31:0] status1_w;
    wire [31:0] status2_w;
    wire [31:0] cal_lo_w;
    wire [31:0] cal_hi_w;
    assign status1_w = {30'h0, data_error, ~fifo_empty}; // [RULE5] [RULE21]
    assign status2_w = {30'h0, overrun_r, overflow_r};
    // one default record only, so no range or mode can appear twice
    assign cal_lo_w  = {CAL_OFFSET, aafc_pkg::REC_DEFAULT,
                        aafc_pkg::REC_LEN, aafc_pkg::REC_TYPE};   // [RULE19] [RULE20]
    assign cal_hi_w  = {16'h0000, range_code, CAL_GAIN};          // [RULE19]

    // read mux, unmapped reads answer zero
    logic [31:0] rd_mux;
    always_comb begin
        case (word_addr)
            aafc_pkg::REG_STATUS1: rd_mux = status1_w;
            aafc_pkg::REG_STATUS2: rd_mux = status2_w;
            aafc_pkg::REG_FIFO:    rd_mux = {16'h0000, mem[rd_ptr_r]}; // [RULE4]
            aafc_pkg::REG_CHAN:    rd_mux = {29'h0, cfg_r.chan};
            aafc_pkg::REG_RANGE:   rd_mux = {29'h0, cfg_r.diff, cfg_r.range};
            aafc_pkg::REG_CTRL:    rd_mux = {31'h0, disable_r};
            aafc_pkg::REG_CAL_LO:  rd_mux = cal_lo_w;
            aafc_pkg::REG_CAL_HI:  rd_mux = cal_hi_w;
            default:               rd_mux = 32'h0000_0000;
        endcase
    end

    // bus response, data registered at the address phase edge
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_r    <= 32'h0000_0000;
            hreadyout_r <= 1'b0;
            wr_pend_r   <= 1'b0;
            wr_addr_r   <= 8'h00;
        end else begin
            hreadyout_r <= 1'b1;
            wr_pend_r   <= wr_access;
            if (wr_access) begin
                wr_addr_r <= word_addr;
            end
            if (rd_access) begin
                hrdata_r <= rd_mux;
            end
        end
    end

    // software controls; reset gives single-ended channel 0
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg_r.chan  <= aafc_pkg::CHAN_RST;    // [RULE18]
            cfg_r.range <= aafc_pkg::RANGE_RST;
            cfg_r.diff  <= aafc_pkg::DIFF_RST;    // [RULE18]
            disable_r   <= 1'b0;
        end else begin
            if (wr_chan) begin
                cfg_r.chan <= hwdata[2:0];
            end
            if (wr_range) begin
                cfg_r.range <= hwdata[1:0];
                cfg_r.diff  <= hwdata[aafc_pkg::RANGE_DIFF_BIT];
            end
            if (wr_ctrl) begin
                disable_r <= hwdata[aafc_pkg::CTRL_DIS_BIT];
            end
        end
    end

    // edge history of the start inputs
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            timer_prev_r  <= 1'b1;
            strobe_prev_r <= 1'b1;
        end else begin
            timer_prev_r  <= sample_timer_output;
            strobe_prev_r <= external_convert_strobe;
        end
    end

    // sequencer: a start during a conversion is skipped, not queued
    always_comb begin
        case (state_r)
            aafc_pkg::ST_IDLE:
                state_nxt = trigger ? aafc_pkg::ST_CONV : aafc_pkg::ST_IDLE;
            aafc_pkg::ST_CONV:
                state_nxt = (conv_cnt_r == '0) ? aafc_pkg::ST_STORE : aafc_pkg::ST_CONV;
            aafc_pkg::ST_STORE:
                state_nxt = aafc_pkg::ST_IDLE;
            default:
                state_nxt = aafc_pkg::ST_IDLE;
        endcase
    end

    // conversion timing keeps total latency under the limit
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_r     <= aafc_pkg::ST_IDLE;
            conv_cnt_r  <= 10'h000;
            adc_start_r <= 1'b0;
            code_r      <= 12'h000;
        end else begin
            state_r     <= state_nxt;
            adc_start_r <= trigger & ~busy;                       // [RULE1]
            if (trigger & ~busy) begin
                conv_cnt_r <= aafc_pkg::CONV_CYC;                 // [RULE6]
            end else if (conv_cnt_r != '0) begin
                conv_cnt_r <= conv_cnt_r - 10'h001;
            end
            if ((state_r == aafc_pkg::ST_CONV) && (conv_cnt_r == '0)) begin
                code_r <= adc_code;                               // [RULE3]
            end
        end
    end

    // fifo storage written at the end of a conversion
    always_ff @(posedge hclk) begin
        if (push) begin
            mem[wr_ptr_r] <= result_word;                         // [RULE3]
        end
    end

    // pointers; a clear wins over a same-cycle push or pop
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_ptr_r <= '0;
            wr_ptr_r <= '0;
            count_r  <= '0;                                       // [RULE18]
        end else if (wr_clear) begin
            rd_ptr_r <= '0;
            wr_ptr_r <= 9'h001;                                   // [RULE12]
            count_r  <= 10'h001;                                  // [RULE12]
        end else begin
            if (pop) begin
                rd_ptr_r <= rd_ptr_r + 9'h001;                    // [RULE4]
            end
            if (push) begin
                wr_ptr_r <= wr_ptr_r + 9'h001;
            end
            case ({push, pop})
                2'b10:   count_r <= count_r + 10'h001;            // [RULE5]
                2'b01:   count_r <= count_r - 10'h001;            // [RULE4]
                default: count_r <= count_r;
            endcase
        end
    end

    // error flags, a new event in the clear cycle still sets
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            overflow_r <= 1'b0;
            overrun_r  <= 1'b0;
        end else begin
            overflow_r <= drop | (overflow_r & ~wr_clear);        // [RULE9] [RULE11]
            overrun_r  <= overrun_set | (overrun_r & ~wr_clear);  // [RULE10] [RULE11]
        end
    end

    // converter setting follows the controls
    logic [5:0] adc_setting_r;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            adc_setting_r <= 6'h00;
        end else begin
            adc_setting_r <= cfg_r;
        end
    end

    assign hrdata      = hrdata_r;
    assign hreadyout   = hreadyout_r;
    assign hresp       = 1'b0;
    assign adc_start   = adc_start_r;
    assign adc_setting = adc_setting_r;

endmodule

// ===== testbench/aafc_monitor.sv
// Purpose: port-level checks of the acquisition FIFO controller
// Assumes: hready is the slave's own hreadyout, single clock domain
// Notes:   bus phase tracking mirrors the zero-wait slave
`timescale 1ns/10ps
module aafc_monitor (
    // clock and reset
    input wire logic        hclk,
    input wire logic        hresetn,
    // bus
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    // converter side
    input wire logic        sample_timer_output,
    input wire logic        external_convert_strobe,
    input wire logic        adc_start,
    input wire logic [5:0]  adc_setting
);
    logic       sto_r;
    logic       ecs_r;
    logic       rd_r;
    logic       wr_r;
    logic [7:0] a_r;
    logic [9:0] gap_r;
    // transfer take and trigger edge, decoded once
    wire take = hsel & htrans[1] & hready;
    wire rise = (sample_timer_output & ~sto_r) | (external_convert_strobe & ~ecs_r);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // history starts high so an input held high at release gives no start
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sto_r <= 1'b1;
            ecs_r <= 1'b1;
            rd_r  <= 1'b0;
            wr_r  <= 1'b0;
            a_r   <= 8'h00;
            gap_r <= 10'h000;
        end else begin
            sto_r <= sample_timer_output;
            ecs_r <= external_convert_strobe;
            rd_r  <= take & ~hwrite;
            wr_r  <= take & hwrite;
            a_r   <= haddr[7:0];
            gap_r <= adc_start ? 10'h3AC : (gap_r == 10'h000 ? 10'h000 : gap_r - 10'h001);
        end
    end
    property p_start_edge; adc_start |-> $past(rise); endproperty
    a_start_edge: assert property (p_start_edge)
        else $error("converter start without a trigger edge");
    property p_start_pulse; $rose(adc_start) |=> !adc_start; endproperty
    a_start_pulse: assert property (p_start_pulse)
        else $error("converter start wider than one cycle");
    property p_start_gap; adc_start |-> gap_r == 10'h000; endproperty
    a_start_gap: assert property (p_start_gap)
        else $error("second start while a conversion runs");
    property p_chan; wr_r && a_r == aafc_pkg::REG_CHAN |-> ##2 adc_setting[2:0] == $past(hwdata[2:0], 2); endproperty
    a_chan: assert property (p_chan)
        else $error("channel setting did not follow the write");
    property p_range; wr_r && a_r == aafc_pkg::REG_RANGE |-> ##2 adc_setting[5:3] == $past(hwdata[2:0], 2); endproperty
    a_range: assert property (p_range)
        else $error("range setting did not follow the write");
    property p_status; rd_r && a_r <= aafc_pkg::REG_STATUS2 |-> hrdata[31:2] == 30'h0; endproperty
    a_status: assert property (p_status)
        else $error("status read has stray upper bits");
    property p_cal; rd_r && a_r == aafc_pkg::REG_CAL_LO |-> hrdata[23:0] == 24'hFF0381; endproperty
    a_cal: assert property (p_cal)
        else $error("calibration record bytes wrong");
    property p_unmapped; rd_r && a_r > aafc_pkg::REG_CAL_HI |-> hrdata == 32'h0; endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");
    property p_reset; $rose(hresetn) |-> adc_setting == 6'h00; endproperty
    a_reset: assert property (p_reset)
        else $error("converter setting not cleared by reset");
endmodule
bind aafc_top aafc_monitor u_mon (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .sample_timer_output(sample_timer_output), .external_convert_strobe(external_convert_strobe),
    .adc_start(adc_start), .adc_setting(adc_setting));

// ===== testbench/test_adc_acquisition_fifo_control.sv
// Purpose: self-checking bench of the acquisition FIFO controller
// Assumes: zero-wait slave, conversion result visible 948 cycles after trigger
// Notes:   a full 512-word overflow exceeds the run length budget
`timescale 1ns/10ps
module test_adc_acquisition_fifo_control;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, adc_start, tmr, stb;
    logic [31:0] haddr, hwdata, hrdata, seed, d, r;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [11:0] adc_code;
    logic [5:0]  adc_setting;
    logic [11:0] codes [4] = '{12'h800, 12'hC00, 12'h000, 12'h400};
    int          failures = 0, comparisons = 0, starts = 0;
    time         t0;
    aafc_top uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .sample_timer_output(tmr),
        .external_convert_strobe(stb), .adc_code(adc_code), .adc_start(adc_start),
        .adc_setting(adc_setting));
    // expected word: sign of the 12-bit code copied into the top nibble
    function automatic logic [31:0] sx(input logic [11:0] c);
        return {16'h0, {4{c[11]}}, c};
    endfunction
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // bus tasks hold each phase until hready is sampled high
    task automatic bw(input logic [7:0] a, input logic [31:0] v);
        haddr <= {24'h0, a}; hwrite <= 1'b1; htrans <= 2'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0; hwdata <= v;
        do @(posedge hclk); while (hreadyout !== 1'b1);
    endtask
    task automatic br(input logic [7:0] a, output logic [31:0] v);
        haddr <= {24'h0, a}; hwrite <= 1'b0; htrans <= 2'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        v = hrdata;
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] v;
        br(a, v);
        chk(v, exp);
    endtask
    // one low cycle then a rise; the other input stays high
    task automatic trig(input logic ext);
        if (ext) stb <= 1'b0; else tmr <= 1'b0;
        @(posedge hclk);
        if (ext) stb <= 1'b1; else tmr <= 1'b1;
        @(posedge hclk);
        t0 = $time;
    endtask
    task automatic wavail();
        logic [31:0] v;
        int n;
        n = 0;
        do begin br(aafc_pkg::REG_STATUS1, v); n++; end while (v[0] !== 1'b1 && n < 600);
        chk({31'h0, ($time - t0) <= 9510}, 32'h1);
    endtask
    task automatic conv(input logic ext, input logic [11:0] code);
        adc_code <= code;
        trig(ext);
        wavail();
        rc(aafc_pkg::REG_FIFO, sx(code));
        rc(aafc_pkg::REG_STATUS1, 32'h0);
    endtask
    task automatic give_verdict();
        $display("failures %0d comparisons %0d", failures, comparisons);
        if (failures == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // clock, start counter and watchdog
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    always @(posedge hclk) if (adc_start === 1'b1) starts++;
    initial begin
        #400000;
        failures++;
        give_verdict();
    end
    // main sequence
    initial begin
        hresetn = 1'b0; hsel = 1'b1; htrans = 2'h0; haddr = 32'h0; hwrite = 1'b0;
        hsize = 3'h2; hwdata = 32'h0; tmr = 1'b1; stb = 1'b1; adc_code = 12'h000;
        seed = 32'h00000054;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rc(aafc_pkg::REG_STATUS1, 32'h0);
        rc(aafc_pkg::REG_CHAN, 32'h0);
        rc(aafc_pkg::REG_RANGE, 32'h0);
        rc(8'h3C, 32'h0);
        chk({31'h0, hresp}, 32'h0);
        bw(aafc_pkg::REG_CLEAR, 32'h0);
        rc(aafc_pkg::REG_STATUS1, 32'h1);
        br(aafc_pkg::REG_FIFO, d);
        rc(aafc_pkg::REG_STATUS1, 32'h0);
        br(aafc_pkg::REG_FIFO, d);
        rc(aafc_pkg::REG_STATUS1, 32'h0);
        rc(aafc_pkg::REG_STATUS2, 32'h0);
        bw(aafc_pkg::REG_CHAN, 32'h5);
        bw(aafc_pkg::REG_RANGE, 32'h6);
        repeat (2) @(posedge hclk);
        chk({26'h0, adc_setting}, 32'h35);
        rc(aafc_pkg::REG_CAL_LO, 32'h00FF0381);
        rc(aafc_pkg::REG_CAL_HI, 32'h00000600);
        for (int i = 0; i < 8; i++) begin
            r = xs();
            conv(i[0], i < 4 ? codes[i] : r[11:0]);
        end
        // two results queued, read back oldest first
        adc_code <= 12'h123; trig(1'b0); wavail();
        adc_code <= 12'hABC; trig(1'b1);
        repeat (960) @(posedge hclk);
        rc(aafc_pkg::REG_FIFO, sx(12'h123));
        rc(aafc_pkg::REG_FIFO, sx(12'hABC));
        // second trigger inside a running conversion
        adc_code <= 12'h7FF; trig(1'b0);
        repeat (10) @(posedge hclk);
        trig(1'b1);
        repeat (960) @(posedge hclk);
        rc(aafc_pkg::REG_STATUS2, 32'h2);
        rc(aafc_pkg::REG_STATUS1, 32'h3);
        bw(aafc_pkg::REG_CLEAR, 32'h0);
        rc(aafc_pkg::REG_STATUS2, 32'h0);
        rc(aafc_pkg::REG_STATUS1, 32'h1);
        br(aafc_pkg::REG_FIFO, d);
        // starts refused while disabled
        bw(aafc_pkg::REG_CTRL, 32'h1);
        trig(1'b0);
        repeat (960) @(posedge hclk);
        rc(aafc_pkg::REG_STATUS1, 32'h0);
        bw(aafc_pkg::REG_CTRL, 32'h0);
        chk(starts, 32'h0000000B);
        give_verdict();
    end
endmodule
